// ===== logic/lhbi_pkg.sv
// shared constants for the display host link, both ends
package lhbi_pkg;
  localparam logic [1:0] MODE_PAR8 = 2'h0;
  localparam logic [1:0] MODE_PAR4 = 2'h1;
  localparam logic [1:0] MODE_SER  = 2'h2;
  localparam logic [1:0] MODE_I2C  = 2'h3;
  localparam int CLK_NS    = 4;
  localparam int T_E_NS    = 200;
  localparam int T_SCL_NS  = 160;
  localparam int T_I2C_NS  = 1300;
  localparam int E_CYC     = (T_E_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCL_CYC   = (T_SCL_NS + CLK_NS - 1) / CLK_NS;
  localparam int I2C_CYC   = (T_I2C_NS + CLK_NS - 1) / CLK_NS;
  localparam int SDA_LINE  = 7;
  localparam int SCL_LINE  = 6;
  localparam int CO_BIT    = 7;
  localparam int SEL_BIT   = 6;
  localparam int SY_MODE   = 12;
  localparam int SY_E      = 11;
  localparam int SY_RW     = 10;
  localparam int SY_SEL    = 9;
  localparam int SY_CS     = 8;
  localparam logic [13:0] SYNC_IDLE = 14'h01FF;
  localparam logic [7:0] LINES_IDLE = 8'hFF;
  localparam logic [7:0] OE_ALL    = 8'hFF;
  localparam logic [7:0] OE_HI_NIB = 8'hF0;
  localparam logic [7:0] OE_SDA    = 8'h80;
  localparam logic [7:0] OE_TWO    = 8'hC0;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [5:0] PAR8_LAST = 6'h02;
  localparam logic [5:0] PAR4_LAST = 6'h06;
  localparam logic [5:0] SER_LAST  = 6'h11;
  localparam logic [5:0] SER_BITEND = 6'h10;
  localparam logic [5:0] I2C_LAST  = 6'h38;
  localparam logic [5:0] I2C_BITEND = 6'h36;
  localparam logic [4:0] I2C_TOP   = 5'h1A;
  // arbitrary slave address
  localparam logic [6:0] I2C_ADDR_DEF = 7'h2A;
endpackage

// ===== logic/lhbi_link_if.sv
// link wires between the host end and the display end
`timescale 1ns/1ps
interface lhbi_link_if;
  logic [1:0] mode;
  logic       enable_strobe;
  logic       read_not_write;
  logic       register_select;
  logic       chip_select_n;
  logic [7:0] host_lines_o;
  logic [7:0] host_lines_oe;
  logic [7:0] dev_lines_o;
  logic [7:0] dev_lines_oe;
  logic [7:0] data_lines;

  // undriven lines float high through the pull-ups
  assign data_lines = (dev_lines_oe & dev_lines_o) | (~dev_lines_oe & host_lines_oe & host_lines_o)
                    | (~dev_lines_oe & ~host_lines_oe & lhbi_pkg::LINES_IDLE);

  modport host (
    output mode, enable_strobe, read_not_write, register_select, chip_select_n,
    output host_lines_o, host_lines_oe,
    input  data_lines
  );
  modport dev (
    input  mode, enable_strobe, read_not_write, register_select, chip_select_n,
    output dev_lines_o, dev_lines_oe,
    input  data_lines
  );
endinterface

// ===== logic/lhbi_dev.sv
// display-side front end of the host link
`timescale 1ns/1ps
module lhbi_dev #(
  parameter logic [6:0] I2C_ADDR = lhbi_pkg::I2C_ADDR_DEF
) (
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  lhbi_link_if.dev        link,
  input  wire logic       busy_i,
  input  wire logic [6:0] addr_ctr_i,
  input  wire logic [7:0] rd_data_i,
  output logic            wr_valid_o,
  output logic [7:0]      wr_data_o,
  output logic            wr_select_o,
  output logic            rd_done_o
);
  typedef enum logic [4:0] {
    I_IDLE = 5'b00001,
    I_ADDR = 5'b00010,
    I_CTRL = 5'b00100,
    I_DATA = 5'b01000,
    I_SKIP = 5'b10000
  } lhbi_i2c_e;

  logic [13:0] sync1, sync2, prev;
  logic        phase, next_phase;
  logic [3:0]  hi, next_hi;
  logic [7:0]  rd_byte, next_rd;
  logic [7:0]  sh, next_sh;
  logic [3:0]  cnt, next_cnt;
  lhbi_i2c_e   st, next_st;
  logic        ack, next_ack;
  logic        co, next_co;
  logic        sel_hold, next_sel_hold;
  logic        next_wv, next_ws, next_rdone;
  logic [7:0]  next_wd;
  logic [7:0]  out, next_out, oe, next_oe;

  logic [1:0]  mode;
  logic [7:0]  lines;
  logic        e_s, rw, sel, cs_n, nib;
  logic        e_rise, e_fall, scl_rise, scl_fall, start, stop;

  // two flops on every pin before any logic looks at it
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      sync1 <= lhbi_pkg::SYNC_IDLE;
      sync2 <= lhbi_pkg::SYNC_IDLE;
      prev  <= lhbi_pkg::SYNC_IDLE;
    end else begin
      sync1 <= {link.mode, link.enable_strobe, link.read_not_write, link.register_select,
                link.chip_select_n, link.data_lines};
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  assign mode  = sync2[lhbi_pkg::SY_MODE +: 2];
  assign lines = sync2[7:0];
  assign e_s   = sync2[lhbi_pkg::SY_E];
  assign rw    = sync2[lhbi_pkg::SY_RW];
  assign sel   = sync2[lhbi_pkg::SY_SEL];
  assign cs_n  = sync2[lhbi_pkg::SY_CS];
  assign nib   = (mode == lhbi_pkg::MODE_PAR4);
  assign e_rise   = e_s & ~prev[lhbi_pkg::SY_E];
  assign e_fall   = ~e_s & prev[lhbi_pkg::SY_E];
  assign scl_rise = lines[lhbi_pkg::SCL_LINE] & ~prev[lhbi_pkg::SCL_LINE];
  assign scl_fall = ~lines[lhbi_pkg::SCL_LINE] & prev[lhbi_pkg::SCL_LINE];
  assign start = lines[lhbi_pkg::SCL_LINE] & prev[lhbi_pkg::SCL_LINE]
               & prev[lhbi_pkg::SDA_LINE] & ~lines[lhbi_pkg::SDA_LINE];
  assign stop  = lines[lhbi_pkg::SCL_LINE] & prev[lhbi_pkg::SCL_LINE]
               & ~prev[lhbi_pkg::SDA_LINE] & lines[lhbi_pkg::SDA_LINE];

  always_comb begin
    next_phase    = phase;
    next_hi       = hi;
    next_rd       = rd_byte;
    next_sh       = sh;
    next_cnt      = cnt;
    next_st       = st;
    next_ack      = ack;
    next_co       = co;
    next_sel_hold = sel_hold;
    next_wv       = 1'b0;
    next_wd       = wr_data_o;
    next_ws       = wr_select_o;
    next_rdone    = 1'b0;
    case (mode)
      lhbi_pkg::MODE_PAR8, lhbi_pkg::MODE_PAR4: begin
        next_st  = I_IDLE;
        next_ack = 1'b0;
        if (e_rise && rw && !(nib && phase)) begin
          next_rd = sel ? rd_data_i : {busy_i, addr_ctr_i};
        end
        if (e_fall && !rw) begin
          if (!nib) begin
            next_wv = 1'b1;
            next_wd = lines;
            next_ws = sel;
          end else if (!phase) begin
            next_hi    = lines[7:4];
            next_phase = 1'b1;
          end else begin
            next_wv    = 1'b1;
            next_wd    = {hi, lines[7:4]};
            next_ws    = sel;
            next_phase = 1'b0;
          end
        end else if (e_fall) begin
          next_phase = nib & ~phase;
          if (sel && !(nib && !phase)) begin
            next_rdone = 1'b1;
          end
        end
      end
      lhbi_pkg::MODE_SER: begin
        next_st    = I_IDLE;
        next_ack   = 1'b0;
        next_phase = 1'b0;
        if (cs_n) begin
          next_cnt = '0;
        end else if (scl_rise) begin
          // msb first on line 7, clocked by line 6
          next_sh = {sh[6:0], lines[lhbi_pkg::SDA_LINE]};
          if (cnt == lhbi_pkg::BYTE_BITS - 4'h1) begin
            next_cnt = '0;
            next_wv  = 1'b1;
            next_wd  = {sh[6:0], lines[lhbi_pkg::SDA_LINE]};
            next_ws  = sel;
          end else begin
            next_cnt = cnt + 4'h1;
          end
        end
      end
      default: begin
        next_phase = 1'b0;
        // start, stop and bits on lines 7 and 6
        if (stop) begin
          next_st  = I_IDLE;
          next_ack = 1'b0;
        end else if (start) begin
          next_st  = I_ADDR;
          next_cnt = '0;
          next_ack = 1'b0;
        end else if (st != I_IDLE && st != I_SKIP) begin
          if (scl_rise && !ack && cnt != lhbi_pkg::BYTE_BITS) begin
            next_sh  = {sh[6:0], lines[lhbi_pkg::SDA_LINE]};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && ack) begin
            next_ack = 1'b0;
          end else if (scl_fall && cnt == lhbi_pkg::BYTE_BITS) begin
            next_cnt = '0;
            case (st)
              I_ADDR: begin
                if (sh == {I2C_ADDR, 1'b0}) begin
                  next_ack = 1'b1;
                  next_st  = I_CTRL;
                end else begin
                  next_st = I_SKIP;
                end
              end
              I_CTRL: begin
                next_ack      = 1'b1;
                next_co       = sh[lhbi_pkg::CO_BIT];
                next_sel_hold = sh[lhbi_pkg::SEL_BIT];
                next_st       = I_DATA;
              end
              default: begin
                next_ack = 1'b1;
                next_wv  = 1'b1;
                next_wd  = sh;
                next_ws  = sel_hold;
                next_st  = co ? I_CTRL : I_DATA;
              end
            endcase
          end
        end
      end
    endcase
    next_oe  = '0;
    next_out = '0;
    if (!mode[1] && e_s && rw) begin
      // nibble reads drive only lines 7..4
      next_oe  = nib ? lhbi_pkg::OE_HI_NIB : lhbi_pkg::OE_ALL;
      next_out = nib ? {(next_phase ? next_rd[3:0] : next_rd[7:4]), 4'h0} : next_rd;
    end else if (mode == lhbi_pkg::MODE_I2C && next_ack) begin
      next_oe = lhbi_pkg::OE_SDA;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      phase       <= 1'b0;
      hi          <= '0;
      rd_byte     <= '0;
      sh          <= '0;
      cnt         <= '0;
      st          <= I_IDLE;
      ack         <= 1'b0;
      co          <= 1'b0;
      sel_hold    <= 1'b0;
      wr_valid_o  <= 1'b0;
      wr_data_o   <= '0;
      wr_select_o <= 1'b0;
      rd_done_o   <= 1'b0;
      out         <= '0;
      oe          <= '0;
    end else begin
      phase       <= next_phase;
      hi          <= next_hi;
      rd_byte     <= next_rd;
      sh          <= next_sh;
      cnt         <= next_cnt;
      st          <= next_st;
      ack         <= next_ack;
      co          <= next_co;
      sel_hold    <= next_sel_hold;
      wr_valid_o  <= next_wv;
      wr_data_o   <= next_wd;
      wr_select_o <= next_ws;
      rd_done_o   <= next_rdone;
      out         <= next_out;
      oe          <= next_oe;
    end
  end

  assign link.dev_lines_o  = out;
  assign link.dev_lines_oe = oe;
endmodule

// ===== logic/lhbi_host.sv
// host-side end of the display link, drives all four modes
`timescale 1ns/1ps
module lhbi_host #(
  parameter logic [6:0] I2C_ADDR = lhbi_pkg::I2C_ADDR_DEF
) (
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  lhbi_link_if.host       link,
  input  wire logic [1:0] mode_i,
  input  wire logic       cmd_valid_i,
  output logic            cmd_ready_o,
  input  wire logic       cmd_read_i,
  input  wire logic       cmd_select_i,
  input  wire logic [7:0] cmd_data_i,
  output logic            rsp_valid_o,
  output logic [7:0]      rsp_data_o
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_RUN  = 3'b010,
    H_DONE = 3'b100
  } lhbi_hst_e;

  lhbi_hst_e   st, next_st;
  logic [5:0]  idx, next_idx;
  logic [8:0]  tmr, next_tmr;
  logic [1:0]  mode, next_mode;
  logic        rd, next_rd, sel, next_sel;
  logic [7:0]  data, next_data, next_rsp;
  logic        next_rsp_valid;
  logic        e, next_e, rw, next_rw, rsel, next_rsel, csn, next_csn;
  logic [7:0]  out, next_out, oe, next_oe;
  logic [7:0]  lines_s1, lines_s2;
  logic [26:0] i2c_vec;
  logic [4:0]  i2c_k;
  logic [2:0]  ser_k;
  logic        sda, scl;

  function automatic logic [8:0] step_of(input logic [1:0] m);
    if (!m[1]) begin
      step_of = 9'(lhbi_pkg::E_CYC);
    end else if (m == lhbi_pkg::MODE_SER) begin
      step_of = 9'(lhbi_pkg::SCL_CYC);
    end else begin
      step_of = 9'(lhbi_pkg::I2C_CYC);
    end
  endfunction

  function automatic logic [5:0] last_of(input logic [1:0] m);
    if (m == lhbi_pkg::MODE_PAR8) begin
      last_of = lhbi_pkg::PAR8_LAST;
    end else if (m == lhbi_pkg::MODE_PAR4) begin
      last_of = lhbi_pkg::PAR4_LAST;
    end else if (m == lhbi_pkg::MODE_SER) begin
      last_of = lhbi_pkg::SER_LAST;
    end else begin
      last_of = lhbi_pkg::I2C_LAST;
    end
  endfunction

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      lines_s1 <= lhbi_pkg::LINES_IDLE;
      lines_s2 <= lhbi_pkg::LINES_IDLE;
    end else begin
      lines_s1 <= link.data_lines;
      lines_s2 <= lines_s1;
    end
  end

  assign cmd_ready_o = (st == H_IDLE);
  // control byte carries the select bit
  assign i2c_vec = {I2C_ADDR, 1'b0, 1'b1, 1'b0, sel, 6'h00, 1'b1, data, 1'b1};
  assign i2c_k   = lhbi_pkg::I2C_TOP - 5'((idx - 6'h01) >> 1);
  assign ser_k   = 3'h7 - 3'((idx - 6'h01) >> 1);

  always_comb begin
    next_st        = st;
    next_idx       = idx;
    next_tmr       = tmr;
    next_mode      = mode;
    next_rd        = rd;
    next_sel       = sel;
    next_data      = data;
    next_rsp       = rsp_data_o;
    next_rsp_valid = 1'b0;
    case (st)
      H_IDLE: begin
        if (cmd_valid_i) begin
          next_mode = mode_i;
          next_rd   = cmd_read_i & ~mode_i[1];
          next_sel  = cmd_select_i;
          next_data = cmd_data_i;
          next_idx  = '0;
          next_tmr  = step_of(mode_i);
          next_st   = H_RUN;
        end
      end
      H_RUN: begin
        if (tmr != '0) begin
          next_tmr = tmr - 9'h001;
        end else begin
          next_tmr = step_of(mode);
          if (idx == last_of(mode)) begin
            next_st = H_DONE;
          end else if (!mode[1] && idx[1:0] == 2'h2) begin
            next_idx = idx + 6'h02;
          end else begin
            next_idx = idx + 6'h01;
          end
          // first nibble read is the high half
          if (!mode[1] && rd && idx[1:0] == 2'h1) begin
            if (mode == lhbi_pkg::MODE_PAR8) begin
              next_rsp = lines_s2;
            end else if (!idx[2]) begin
              next_rsp[7:4] = lines_s2[7:4];
            end else begin
              next_rsp[3:0] = lines_s2[7:4];
            end
          end
        end
      end
      default: begin
        // one whole byte per command, status only after both nibbles
        next_rsp_valid = rd;
        next_st        = H_IDLE;
      end
    endcase
  end

  always_comb begin
    next_e    = 1'b0;
    next_rw   = 1'b0;
    next_rsel = 1'b0;
    next_csn  = 1'b1;
    next_out  = '0;
    next_oe   = '0;
    sda       = 1'b1;
    scl       = 1'b1;
    if (st == H_RUN) begin
      if (!mode[1]) begin
        next_rsel = sel;
        next_rw   = rd;
        next_e    = (idx[1:0] == 2'h1);
        if (!rd) begin
          next_oe = (mode == lhbi_pkg::MODE_PAR8) ? lhbi_pkg::OE_ALL : lhbi_pkg::OE_HI_NIB;
          next_out = (mode == lhbi_pkg::MODE_PAR8) ? data :
                     {(idx[2] ? data[3:0] : data[7:4]), 4'h0};
        end
      end else if (mode == lhbi_pkg::MODE_SER) begin
        // chip select low two steps before the first rising clock
        next_csn  = 1'b0;
        next_rsel = sel;
        sda       = data[ser_k];
        scl       = (idx != '0) && !idx[0] && (idx <= lhbi_pkg::SER_BITEND);
        next_oe   = lhbi_pkg::OE_TWO;
        next_out  = {sda, scl, 6'h00};
      end else begin
        if (idx == '0) begin
          sda = 1'b0;
        end else if (idx <= lhbi_pkg::I2C_BITEND) begin
          scl = ~idx[0];
          sda = i2c_vec[i2c_k];
        end else begin
          scl = idx[0] ? 1'b0 : 1'b1;
          sda = 1'b0;
        end
        next_oe = {~sda, ~scl, 6'h00};
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      st          <= H_IDLE;
      idx         <= '0;
      tmr         <= '0;
      mode        <= lhbi_pkg::MODE_PAR8;
      rd          <= 1'b0;
      sel         <= 1'b0;
      data        <= '0;
      rsp_data_o  <= '0;
      rsp_valid_o <= 1'b0;
      e           <= 1'b0;
      rw          <= 1'b0;
      rsel        <= 1'b0;
      csn         <= 1'b1;
      out         <= '0;
      oe          <= '0;
    end else begin
      st          <= next_st;
      idx         <= next_idx;
      tmr         <= next_tmr;
      mode        <= next_mode;
      rd          <= next_rd;
      sel         <= next_sel;
      data        <= next_data;
      rsp_data_o  <= next_rsp;
      rsp_valid_o <= next_rsp_valid;
      e           <= next_e;
      rw          <= next_rw;
      rsel        <= next_rsel;
      csn         <= next_csn;
      out         <= next_out;
      oe          <= next_oe;
    end
  end

  assign link.mode            = mode;
  assign link.enable_strobe   = e;
  assign link.read_not_write  = rw;
  assign link.register_select = rsel;
  assign link.chip_select_n   = csn;
  assign link.host_lines_o    = out;
  assign link.host_lines_oe   = oe;
endmodule

// ===== verification/lhbi_link_assertions.sv
// wire-level checks on the link between host end and display end
`timescale 1ns/1ps
module lhbi_link_assertions (
  input wire logic       mclk_i,
  input wire logic       nrst_i,
  input wire logic [1:0] mode,
  input wire logic       enable_strobe,
  input wire logic       read_not_write,
  input wire logic       register_select,
  input wire logic       chip_select_n,
  input wire logic [7:0] host_lines_o,
  input wire logic [7:0] host_lines_oe,
  input wire logic [7:0] dev_lines_o,
  input wire logic [7:0] dev_lines_oe,
  input wire logic [7:0] data_lines
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  a_nib_upper_only: assert property (mode == lhbi_pkg::MODE_PAR4 && enable_strobe |->
    host_lines_oe[3:0] == 4'h0 && dev_lines_oe[3:0] == 4'h0) else $error("nibble strobe with low lines driven");
  a_byte_all_lines: assert property (mode == lhbi_pkg::MODE_PAR8 && enable_strobe && !read_not_write |->
    host_lines_oe == lhbi_pkg::OE_ALL) else $error("byte write not on all lines");
  a_byte_read_drive: assert property (mode == lhbi_pkg::MODE_PAR8 && read_not_write && enable_strobe
    && $past(enable_strobe, 4) |-> dev_lines_oe == lhbi_pkg::OE_ALL) else $error("byte read not driven");
  a_nib_read_drive: assert property (mode == lhbi_pkg::MODE_PAR4 && read_not_write && enable_strobe
    && $past(enable_strobe, 4) |-> dev_lines_oe == lhbi_pkg::OE_HI_NIB) else $error("nibble read not driven");
  a_ser_two_lines: assert property (mode == lhbi_pkg::MODE_SER |-> (host_lines_oe & 8'h3F) == 8'h00
    && dev_lines_oe == 8'h00 && !enable_strobe) else $error("serial mode uses other lines");
  a_i2c_two_lines: assert property (mode == lhbi_pkg::MODE_I2C |-> (host_lines_oe & 8'h3F) == 8'h00
    && (dev_lines_oe & 8'h7F) == 8'h00) else $error("i2c mode uses other lines");
  a_cs_before_clk: assert property (mode == lhbi_pkg::MODE_SER && host_lines_oe[6] && $past(host_lines_oe[6])
    && $rose(data_lines[6]) |-> !chip_select_n && !$past(chip_select_n)) else $error("serial clock without select");
  a_select_held: assert property (enable_strobe && $past(enable_strobe) |->
    $stable(register_select) && $stable(read_not_write)) else $error("select moved during strobe");
  a_data_held: assert property (enable_strobe && $past(enable_strobe) && !read_not_write |->
    $stable(host_lines_o)) else $error("write data moved during strobe");
  a_no_contention: assert property (!mode[1] |-> (dev_lines_oe & host_lines_oe) == 8'h00)
    else $error("both ends drive a line");
endmodule

// ===== verification/lcd_host_bus_interface_test.sv
// self-checking bench: host end and display end joined across the link
`timescale 1ns/1ps
module lcd_host_bus_interface_test;
  logic        mclk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [1:0]  mode_i = 2'h0;
  logic        cmd_valid_i = 1'b0, cmd_read_i = 1'b0, cmd_select_i = 1'b0;
  logic [7:0]  cmd_data_i = 8'h00, rd_data_i = 8'h00, rsp_data_o, wr_data_o, wr2_data;
  logic        busy_i = 1'b0;
  logic [6:0]  addr_ctr_i = 7'h00;
  logic        cmd_ready_o, rsp_valid_o, wr_valid_o, wr_select_o, rd_done_o, wr2_valid, wr2_select;
  logic [8:0]  wr_q[$], rsp_q[$], wr2_q[$];
  logic [31:0] seed = 32'h3964;
  int          mismatches = 0, num_checks = 0, rd_done_seen = 0, rd_done_want = 0, n;

  always #2 mclk_i = ~mclk_i;

  lhbi_link_if link();
  lhbi_link_if link2();
  lhbi_host lhbi_host_inst (.mclk_i, .nrst_i, .link(link.host), .mode_i, .cmd_valid_i, .cmd_ready_o,
    .cmd_read_i, .cmd_select_i, .cmd_data_i, .rsp_valid_o, .rsp_data_o);
  lhbi_dev lhbi_dev_inst (.mclk_i, .nrst_i, .link(link.dev), .busy_i, .addr_ctr_i, .rd_data_i,
    .wr_valid_o, .wr_data_o, .wr_select_o, .rd_done_o);
  // second display end, driven by the bench with broken host behaviour
  lhbi_dev lhbi_dev_fault_inst (.mclk_i, .nrst_i, .link(link2.dev), .busy_i(1'b0), .addr_ctr_i(7'h00),
    .rd_data_i(8'h00), .wr_valid_o(wr2_valid), .wr_data_o(wr2_data), .wr_select_o(wr2_select), .rd_done_o());
  lhbi_link_assertions lhbi_link_assertions_inst (.mclk_i, .nrst_i, .mode(link.mode),
    .enable_strobe(link.enable_strobe), .read_not_write(link.read_not_write),
    .register_select(link.register_select), .chip_select_n(link.chip_select_n),
    .host_lines_o(link.host_lines_o), .host_lines_oe(link.host_lines_oe), .dev_lines_o(link.dev_lines_o),
    .dev_lines_oe(link.dev_lines_oe), .data_lines(link.data_lines));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic cmp_byte(input string what, input logic [8:0] exp, input logic [8:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_count(input string what, input int exp, input int got);
    num_checks++;
    if (got != exp) begin
      mismatches++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // oldest note against each result; no note means a result that should not exist
  task automatic take(ref logic [8:0] q[$], input logic [8:0] got, input string what);
    cmp_byte(what, (q.size() > 0) ? q.pop_front() : 9'bx, got);
  endtask

  always @(negedge mclk_i) begin
    if (wr_valid_o === 1'b1) take(wr_q, {wr_select_o, wr_data_o}, "write");
    if (rsp_valid_o === 1'b1) take(rsp_q, {1'b0, rsp_data_o}, "read");
    if (wr2_valid === 1'b1) take(wr2_q, {wr2_select, wr2_data}, "fault end write");
    if (rd_done_o === 1'b1) rd_done_seen++;
  end

  // one host command with random data; the expected result is noted first
  // display-side inputs change only once the previous command has finished
  task automatic send(input logic [1:0] m, input logic rd, input logic sel);
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (cmd_ready_o !== 1'b1 && n < 40000);
    if (n >= 40000) begin
      mismatches++;
      test_done();
    end
    if (m != mode_i) repeat (16) @(posedge mclk_i);
    @(posedge mclk_i);
    seed = xs(seed);
    {busy_i, addr_ctr_i, rd_data_i} <= seed[15:0];
    mode_i <= m;
    cmd_read_i <= rd;
    cmd_select_i <= sel;
    cmd_data_i <= seed[23:16];
    cmd_valid_i <= 1'b1;
    if (!rd) wr_q.push_back({sel, seed[23:16]});
    else rsp_q.push_back({1'b0, sel ? seed[7:0] : seed[15:8]});
    if (rd && sel) rd_done_want++;
    // host is idle, so the command is taken at this edge
    @(posedge mclk_i);
    cmd_valid_i <= 1'b0;
  endtask

  // serial frame on the second link with a bench-made clock of 125 ns
  task automatic ser2(input logic csn, input logic [7:0] d);
    @(posedge mclk_i);
    #1.25;
    if (!csn) wr2_q.push_back({1'b0, d});
    link2.chip_select_n <= csn;
    link2.host_lines_o <= 8'h00;
    link2.host_lines_oe <= lhbi_pkg::OE_TWO;
    for (int i = 7; i >= 0; i--) begin
      #62.5 link2.host_lines_o <= {d[i], 7'h00};
      #62.5 link2.host_lines_o <= {d[i], 7'h40};
    end
    #62.5 link2.host_lines_oe <= 8'h00;
    link2.chip_select_n <= 1'b1;
    #500;
  endtask

  // one nibble strobe, with junk on the lower lines
  task automatic nib2(input logic [3:0] v);
    @(posedge mclk_i);
    link2.host_lines_o <= {v, ~v};
    link2.host_lines_oe <= lhbi_pkg::OE_ALL;
    repeat (4) @(posedge mclk_i);
    link2.enable_strobe <= 1'b1;
    repeat (60) @(posedge mclk_i);
    link2.enable_strobe <= 1'b0;
    repeat (60) @(posedge mclk_i);
    link2.host_lines_oe <= 8'h00;
  endtask

  initial begin
    link2.mode = lhbi_pkg::MODE_SER;
    link2.enable_strobe = 1'b0;
    link2.read_not_write = 1'b0;
    link2.register_select = 1'b0;
    link2.chip_select_n = 1'b1;
    link2.host_lines_o = 8'hFF;
    link2.host_lines_oe = 8'h00;
    repeat (8) @(posedge mclk_i);
    nrst_i <= 1'b1;
    for (int m = 0; m < 4; m++)
      for (int k = 0; k < ((m == 3) ? 2 : 4); k++) send(m[1:0], 1'b0, k[0]);
    for (int m = 0; m < 2; m++)
      for (int k = 0; k < 4; k++) send(m[1:0], 1'b1, k[0]);
    send(lhbi_pkg::MODE_PAR4, 1'b0, 1'b1);
    ser2(1'b1, 8'hA5);
    ser2(1'b0, 8'h3C);
    @(posedge mclk_i);
    link2.mode <= lhbi_pkg::MODE_PAR4;
    nib2(4'h9);
    wr2_q.push_back({1'b0, 8'h96});
    nib2(4'h6);
    n = 0;
    while (wr_q.size() + rsp_q.size() + wr2_q.size() != 0 && n < 4000) begin
      @(posedge mclk_i);
      n++;
    end
    cmp_count("pending results", 0, wr_q.size() + rsp_q.size() + wr2_q.size());
    cmp_count("read done pulses", rd_done_want, rd_done_seen);
    test_done();
  end
endmodule
